// ### rtl/spb_master.sv
// slow peripheral bus master: sequencer for flash and framer ports
//
// Contract
// - 26-bit address goes out one byte per port cycle over three cycles; bits 25:24 are ORed into the third byte.
// - two slave ports, chip select 0 for flash, 1 for framer.
// - each flash write is exactly one 8-bit external cycle.
// - flash read width resets to 32-bit; four byte reads pack to a word.
// - 8-bit read mode: one read cycle, byte returned in bits 7 to 0.
// - no 16-bit flash read mode; only 8 and 32 bit widths selectable.
// - 64 MB space split into two 32 MB segments, one select each.
// - bursts become independent single transfers on the external bus.
// - one idle cycle between back-to-back external transactions.
// - port clock is the bus clock divided by the divider register; a divisor of one or zero holds it high.
// - address latch enable low for the three address cycles, then high.
// - low two address outputs held stable for the whole transaction.
// - fixed-timed strobes follow setup, pulse and hold counts only.
// - write: data and select, strobe after setup, select off hold later.
// - self-timed write strobe ends on device acknowledge.
// - self-timed write time-out from 255 ends transfer, flags, interrupts.
// - read: tri-state turnaround cycle after address, then select.
// - fixed read: strobe after setup for pulse count; select off next cycle.
// - self-timed read ended by acknowledge, time-out from 256.
// - pack shift clock, pack output enable and direction outputs.
// - data width field: 0 for 8, 1 for 16, 2 for 32 bits.
// - protocol select resets to mode 0, generic 8-bit.
`timescale 1ns/10ps
module spb_master
  import spb_pkg::*;
#(
  parameter int DIV_W = 8,
  parameter int TIM_W = 4
) (
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              resetn_i,
  // configuration
  input  wire logic              flash_read_width_select_i,
  input  wire logic [2:0]        interface_protocol_select_i,
  input  wire logic [1:0]        data_width_field_i,
  input  wire logic [DIV_W-1:0]  port_clock_divider_reg_i,
  input  wire logic [TIM_W-1:0]  setup_cnt_i,
  input  wire logic [TIM_W-1:0]  pulse_cnt_i,
  input  wire logic [TIM_W-1:0]  hold_cnt_i,
  input  wire logic              self_timed_i,
  input  wire logic              cfg_load_i,
  // internal master request
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [7:0]        req_wdata_i,
  output logic                   rsp_valid_o,
  output logic [31:0]            rsp_rdata_o,
  output logic                   rsp_timeout_o,
  output logic                   timeout_irq_o,
  // status
  output logic                   flash_read_width_o,
  output logic [2:0]             interface_protocol_o,
  output logic [1:0]             data_width_o,
  output logic [ADDR_W-1:0]      timeout_addr_o,
  // external pins
  output logic                   port_clock_o,
  output logic                   addr_latch_enable_n_o,
  input  wire logic [7:0]        shared_addr_data_bus_i,
  output logic [7:0]             shared_addr_data_bus_o,
  output logic                   shared_addr_data_bus_oe_o,
  output logic [1:0]             low_addr_o,
  output logic [1:0]             chip_select_n_o,
  output logic                   write_strobe_n_o,
  output logic                   read_strobe_n_o,
  input  wire logic              device_acknowledge_n_i,
  output logic                   pack_shift_clock_o,
  output logic                   pack_output_enable_n_o,
  output logic                   pack_direction_o
);
  spb_tick_if tck ();
  spb_state_t state_ff;
  logic                frm_ff;
  logic [2:0]          proto_ff;
  logic [1:0]          dw_ff;
  logic [DIV_W-1:0]    div_ff;
  logic [ADDR_W-1:0]   addr_ff;
  logic [7:0]          wdata_ff;
  logic                wr_ff;
  logic                st_ff;
  logic [1:0]          byte_ff;
  logic [1:0]          nbytes_ff;
  logic [1:0]          acyc_ff;
  logic [TIM_W-1:0]    tcnt_ff;
  logic [8:0]          tmo_ff;
  logic [31:0]         pack_ff;
  logic [ADDR_W-1:0]   cur_addr;
  logic                seg;
  logic                ack;
  logic                tmo_hit;
  logic                tmo_flag_ff;

  spb_clkdiv #(.DIV_W(DIV_W)) u_div (
    .clock_i   (clock_i),
    .resetn_i  (resetn_i),
    .divisor_i (div_ff),
    .tck       (tck)
  );

  // configuration registers; only 8 and 32 bit flash reads exist
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frm_ff   <= FRM_RESET_VALUE;
      proto_ff <= PROTO_RESET_VAL;
      dw_ff    <= DW_RESET_VALUE;
      div_ff   <= DIV_RESET_VALUE;
    end else if (cfg_load_i) begin
      frm_ff   <= flash_read_width_select_i;
      proto_ff <= interface_protocol_select_i;
      // encoding 3 is not a width, keep the old value
      if (data_width_field_i != 2'h3)
        dw_ff <= data_width_field_i;
      div_ff   <= port_clock_divider_reg_i;
    end
  end

  assign flash_read_width_o   = frm_ff;
  assign interface_protocol_o = proto_ff;
  assign data_width_o         = dw_ff;

  // byte k of a packed read lives at base + k
  assign cur_addr = addr_ff + ADDR_W'(byte_ff);
  assign seg      = addr_ff[SEG_BIT];
  assign ack      = !device_acknowledge_n_i;
  assign tmo_hit  = st_ff && (tmo_ff == 9'h000);
  assign req_ready_o = (state_ff == SPB_IDLE);

  // request capture; a burst arrives as separate requests
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_ff   <= '0;
      wdata_ff  <= 8'h00;
      wr_ff     <= 1'b0;
      st_ff     <= 1'b0;
      nbytes_ff <= 2'h0;
    end else if (req_valid_i && req_ready_o) begin
      addr_ff   <= req_addr_i;
      wdata_ff  <= req_wdata_i;
      wr_ff     <= req_write_i;
      st_ff     <= self_timed_i;
      // writes are one byte framer port and 8-bit mode one read
      nbytes_ff <= (req_write_i || req_addr_i[SEG_BIT] || frm_ff == FRM_WIDTH_8)
                   ? 2'h0 : 2'h3;
    end
  end

  // sequencer, leaves idle on the bus clock when a request is valid, then advances on port clock ticks
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= SPB_IDLE;
      acyc_ff  <= 2'h0;
      tcnt_ff  <= '0;
      byte_ff  <= 2'h0;
    end else if (state_ff == SPB_IDLE) begin
      if (req_valid_i) begin
        state_ff <= SPB_ADDR;
        acyc_ff  <= 2'h0;
        byte_ff  <= 2'h0;
      end
    end else if (tck.tick) begin
      case (state_ff)
        SPB_ADDR: begin
          acyc_ff <= acyc_ff + 2'h1;
          if (acyc_ff == 2'(ADDR_CYCLES - 1)) begin
            state_ff <= wr_ff ? SPB_SETUP : SPB_TURN;
            tcnt_ff  <= setup_cnt_i;
          end
        end
        SPB_TURN: state_ff <= SPB_SETUP;
        SPB_SETUP: begin
          // zero setup still spends one port cycle in setup before the strobe
          if (tcnt_ff == '0) begin
            state_ff <= SPB_PULSE;
            tcnt_ff  <= pulse_cnt_i;
          end else
            tcnt_ff <= tcnt_ff - TIM_W'(1);
        end
        SPB_PULSE: begin
          // self-timed ends on acknowledge or time-out, else pulse count
          if (st_ff ? (ack || tmo_hit) : (tcnt_ff <= TIM_W'(1))) begin
            state_ff <= SPB_HOLD;
            // read select drops one cycle after strobe
            tcnt_ff  <= wr_ff ? hold_cnt_i : TIM_W'(1);
          end else if (!st_ff)
            tcnt_ff <= tcnt_ff - TIM_W'(1);
        end
        SPB_HOLD: begin
          if (tcnt_ff <= TIM_W'(1)) begin
            state_ff <= SPB_GAP;
          end else
            tcnt_ff <= tcnt_ff - TIM_W'(1);
        end
        SPB_GAP: begin
          // one idle port cycle between transactions
          if (byte_ff != nbytes_ff && !tmo_flag_ff) begin
            byte_ff  <= byte_ff + 2'h1;
            acyc_ff  <= 2'h0;
            state_ff <= SPB_ADDR;
          end else
            state_ff <= SPB_IDLE;
        end
        default: state_ff <= SPB_IDLE;
      endcase
    end
  end

  // time-out counter; 255 for writes, 256 for reads
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i)
      tmo_ff <= 9'h000;
    else if (state_ff == SPB_SETUP)
      tmo_ff <= wr_ff ? 9'(TMO_WR_START) : 9'(TMO_RD_START);
    else if (state_ff == SPB_PULSE && tck.tick && tmo_ff != 9'h000)
      tmo_ff <= tmo_ff - 9'h001;
  end

  // the outcome is kept until the answer, so an acknowledge that lands in
  // the tick where the counter runs out is reported as a normal end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i)
      tmo_flag_ff <= 1'b0;
    else if (state_ff == SPB_IDLE)
      tmo_flag_ff <= 1'b0;
    else if (state_ff == SPB_PULSE && tck.tick && st_ff && !ack && tmo_hit)
      tmo_flag_ff <= 1'b1;
  end

  // read packing, lowest address in the lowest lane
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i)
      pack_ff <= 32'h0000_0000;
    else if (state_ff == SPB_ADDR && acyc_ff == 2'h0 && byte_ff == 2'h0)
      pack_ff <= 32'h0000_0000;
    else if (state_ff == SPB_PULSE && tck.tick && !wr_ff)
      pack_ff[byte_ff*8 +: 8] <= shared_addr_data_bus_i;
  end

  // answer, time-out flag and time-out address register
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp_valid_o    <= 1'b0;
      rsp_rdata_o    <= 32'h0000_0000;
      rsp_timeout_o  <= 1'b0;
      timeout_irq_o  <= 1'b0;
      timeout_addr_o <= '0;
    end else begin
      rsp_valid_o   <= 1'b0;
      timeout_irq_o <= 1'b0;
      if (state_ff == SPB_PULSE && tck.tick && st_ff && !ack && tmo_hit) begin
        // irq and register update land together
        timeout_irq_o  <= 1'b1;
        timeout_addr_o <= cur_addr;
      end
      if (state_ff == SPB_GAP && tck.tick && (byte_ff == nbytes_ff || tmo_flag_ff)) begin
        rsp_valid_o   <= 1'b1;
        rsp_rdata_o   <= pack_ff;
        rsp_timeout_o <= tmo_flag_ff;
      end
    end
  end

  // pins: address byte order low, middle, high; small parts alias
  // three latches hold 24 bits, so bits 25:24 are folded into the third byte;
  // the segment reaches the far side through the chip selects instead
  always_comb begin
    shared_addr_data_bus_o    = 8'h00;
    shared_addr_data_bus_oe_o = 1'b0;
    case (state_ff)
      SPB_ADDR: begin
        shared_addr_data_bus_oe_o = 1'b1;
        shared_addr_data_bus_o    = (acyc_ff == 2'h0) ? cur_addr[7:0] :
                                    (acyc_ff == 2'h1) ? cur_addr[15:8] :
                                    {6'h00, cur_addr[25:24]} | cur_addr[23:16];
      end
      SPB_SETUP, SPB_PULSE, SPB_HOLD: begin
        shared_addr_data_bus_oe_o = wr_ff;
        shared_addr_data_bus_o    = wdata_ff;
      end
      default: ;
    endcase
  end

  assign addr_latch_enable_n_o = (state_ff != SPB_ADDR);
  assign low_addr_o      = (state_ff == SPB_IDLE) ? 2'h0 : cur_addr[1:0];
  assign chip_select_n_o = (state_ff == SPB_SETUP || state_ff == SPB_PULSE ||
                            state_ff == SPB_HOLD) ? (seg ? 2'b01 : 2'b10)
                                                  : 2'b11;
  assign write_strobe_n_o = !(state_ff == SPB_PULSE && wr_ff);
  assign read_strobe_n_o  = !(state_ff == SPB_PULSE && !wr_ff);
  assign port_clock_o     = tck.port_clock;
  // pack helpers idle at 8-bit width in any mode; otherwise shift clock follows the strobe, enable the hold
  assign pack_shift_clock_o     = (dw_ff != DW_8BIT) && (state_ff == SPB_PULSE);
  assign pack_output_enable_n_o = !((dw_ff != DW_8BIT) && state_ff == SPB_HOLD);
  assign pack_direction_o       = !wr_ff;
endmodule

// ### shared/spb_pkg.sv
// constants and types shared by the slow peripheral bus master
package spb_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int          ADDR_W          = 26;
  localparam int          SEG_BIT         = 25;
  localparam int          TMO_WR_START    = 255;
  localparam int          TMO_RD_START    = 256;
  localparam logic [1:0]  DW_8BIT         = 2'h0;
  localparam logic [1:0]  DW_16BIT        = 2'h1;
  localparam logic [1:0]  DW_32BIT        = 2'h2;
  localparam logic [2:0]  PROTO_GENERIC   = 3'h0;
  localparam logic        FRM_WIDTH_8     = 1'b0;
  localparam logic        FRM_WIDTH_32    = 1'b1;
  localparam logic        FRM_RESET_VALUE = FRM_WIDTH_32;
  localparam logic [2:0]  PROTO_RESET_VAL = PROTO_GENERIC;
  localparam logic [1:0]  DW_RESET_VALUE  = DW_8BIT;
  localparam logic [7:0]  DIV_RESET_VALUE = 8'h01;
  localparam int          ADDR_CYCLES     = 3;

  typedef enum logic [3:0] {
    SPB_IDLE, SPB_ADDR, SPB_TURN, SPB_SETUP, SPB_PULSE, SPB_HOLD, SPB_GAP
  } spb_state_t;
endpackage

// ### shared/spb_tick_if.sv
// port clock tick carried from divider to sequencer
`timescale 1ns/10ps
interface spb_tick_if;
  logic tick;
  logic port_clock;
  modport src (output tick, output port_clock);
  modport dst (input tick, input port_clock);
endinterface

// ### rtl/spb_clkdiv.sv
// port clock divider: one tick per divided period
`timescale 1ns/10ps
module spb_clkdiv
  import spb_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  // divisor
  input  wire logic [DIV_W-1:0] divisor_i,
  // tick out
  spb_tick_if.src               tck
);
  logic [DIV_W-1:0] cnt_ff;
  logic             clk_ff;
  logic             tick_ff;
  logic [DIV_W-1:0] lim;

  // divisor of zero behaves like one so the port never stalls
  assign lim = (divisor_i == '0) ? DIV_W'(1) : divisor_i;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
      clk_ff  <= 1'b0;
    end else if (cnt_ff >= lim - DIV_W'(1)) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b1;
      clk_ff  <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + DIV_W'(1);
      tick_ff <= 1'b0;
      // high for the first half of the period, rounded up; a divisor of one
      // leaves it high, since a register cannot follow the bus clock itself
      clk_ff  <= (cnt_ff + DIV_W'(1)) < (lim - (lim >> 1));
    end
  end

  assign tck.tick       = tick_ff;
  assign tck.port_clock = clk_ff;
endmodule

// ### bench/spb_master_props.sv
// pin-level assertions for the slow peripheral bus master
`timescale 1ns/10ps
module spb_master_props
  import spb_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              resetn_i,
  input wire logic              req_valid_i,
  input wire logic              req_ready_o,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic              rsp_valid_o,
  input wire logic              rsp_timeout_o,
  input wire logic              timeout_irq_o,
  input wire logic              addr_latch_enable_n_o,
  input wire logic              shared_addr_data_bus_oe_o,
  input wire logic [1:0]        low_addr_o,
  input wire logic [1:0]        chip_select_n_o,
  input wire logic              write_strobe_n_o,
  input wire logic              read_strobe_n_o,
  input wire logic [1:0]        data_width_o,
  input wire logic              pack_shift_clock_o,
  input wire logic              pack_output_enable_n_o,
  input wire logic              pack_direction_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  ale_three_cyc_a: assert property (
    $fell(addr_latch_enable_n_o) |-> (!addr_latch_enable_n_o)[*3] ##1 addr_latch_enable_n_o)
    else $error("latch enable not low for three cycles");
  addr_driven_a: assert property (
    !addr_latch_enable_n_o |-> shared_addr_data_bus_oe_o) else $error("address not driven");
  one_select_a: assert property (
    chip_select_n_o != 2'b00) else $error("both selects low");
  write_phase_a: assert property (
    !write_strobe_n_o |-> shared_addr_data_bus_oe_o && chip_select_n_o != 2'b11
      && read_strobe_n_o) else $error("write strobe without data or select");
  read_turn_a: assert property (
    !read_strobe_n_o |-> !shared_addr_data_bus_oe_o && chip_select_n_o != 2'b11)
    else $error("bus driven during read");
  read_release_a: assert property (
    $rose(read_strobe_n_o) |-> chip_select_n_o != 2'b11 ##1 chip_select_n_o == 2'b11)
    else $error("select not released one cycle after read strobe");
  low_addr_hold_a: assert property (
    chip_select_n_o != 2'b11 |-> $stable(low_addr_o)) else $error("low address moved");
  idle_gap_a: assert property (
    $rose(&chip_select_n_o) |-> addr_latch_enable_n_o && write_strobe_n_o && read_strobe_n_o)
    else $error("no idle cycle");
  tmo_irq_a: assert property (
    timeout_irq_o |-> ##[1:1000] rsp_valid_o && rsp_timeout_o)
    else $error("irq apart from time-out");
  pack_idle_a: assert property (
    data_width_o == DW_8BIT |-> !pack_shift_clock_o && pack_output_enable_n_o)
    else $error("pack helpers active at 8-bit width");
  pack_clock_a: assert property (
    data_width_o != DW_8BIT && !(write_strobe_n_o && read_strobe_n_o) |-> pack_shift_clock_o)
    else $error("no pack shift clock during strobe");
  pack_dir_a: assert property (
    !(write_strobe_n_o && read_strobe_n_o) |-> pack_direction_o == write_strobe_n_o)
    else $error("pack direction wrong");
  // the bench keeps the address steady until the answer, so it is read late here
  seg_select_a: assert property (
    req_valid_i && req_ready_o |-> ##[3:6]
      chip_select_n_o == {!req_addr_i[SEG_BIT], req_addr_i[SEG_BIT]})
    else $error("wrong segment select");
endmodule

bind spb_master spb_master_props u_props (.clock_i, .resetn_i, .req_valid_i, .req_ready_o,
  .req_addr_i, .rsp_valid_o, .rsp_timeout_o, .timeout_irq_o, .addr_latch_enable_n_o,
  .shared_addr_data_bus_oe_o, .low_addr_o, .chip_select_n_o, .write_strobe_n_o,
  .read_strobe_n_o, .data_width_o, .pack_shift_clock_o, .pack_output_enable_n_o,
  .pack_direction_o);

// ### bench/spb_flash_model.sv
// behavioural flash: latches the address, answers reads, acknowledges strobes
`timescale 1ns/10ps
module spb_flash_model (
  input  wire logic       clock_i,
  input  wire logic       ale_n_i,
  input  wire logic [1:0] cs_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       rd_n_i,
  input  wire logic [7:0] bus_i,
  input  wire logic [7:0] ack_dly_i,
  output logic      [7:0] bus_o,
  output logic            ack_n_o,
  output logic     [23:0] addr_o,
  output logic      [7:0] wbyte_o
);
  logic [7:0] cnt;
  initial begin
    addr_o = '0;
    wbyte_o = '0;
    bus_o = 8'h00;
    ack_n_o = 1'b1;
    cnt = 8'h00;
  end
  always @(posedge clock_i) begin
    if (!ale_n_i) addr_o <= {bus_i, addr_o[23:8]};
    if (!wr_n_i && cs_n_i != 2'b11) wbyte_o <= bus_i;
    cnt <= (wr_n_i && rd_n_i) ? 8'h00 : cnt + 8'h01;
    // a zero delay never answers, which is how a time-out is provoked
    ack_n_o <= !(ack_dly_i != 8'h00 && cnt + 8'h01 >= ack_dly_i && !(wr_n_i && rd_n_i));
    // only the low address byte reaches the array, so upper space aliases
    bus_o <= (!rd_n_i && cs_n_i != 2'b11) ? addr_o[7:0] ^ 8'ha5 : ~bus_o;
  end
endmodule

// ### bench/tb_slow_peripheral_bus_master.sv
// self-checking bench for the slow peripheral bus master
`timescale 1ns/10ps
module tb_slow_peripheral_bus_master;
  import spb_pkg::*;
  logic              clock_i = 0, resetn_i = 0, fw = 1, load = 0, st = 0, valid = 0, wr = 0;
  logic [1:0]        dw = 0, cs_n, dw_o;
  logic [2:0]        proto_o;
  logic [3:0]        su = 4'h1, pw = 4'h2, hd = 4'h1;
  logic [ADDR_W-1:0] addr = '0, to_addr;
  logic [7:0]        wdata = 0, ack_dly = 0, div = 8'h01, dout, bus, mbus, wbyte;
  logic              oe, ale_n, wr_n, rd_n, ack_n, ready, rvalid, rto, irq, fw_o, pclk;
  logic [31:0]       rdata, got, exp;
  logic [23:0]       maddr;
  int                n_mismatch = 0, num_checks = 0, n_irq = 0, n_pclk = 0, n0;
  time               t0;
  always #5 clock_i = ~clock_i;
  assign bus = oe ? dout : mbus;
  // irq is a one-cycle pulse, so it is counted mid-cycle
  always @(negedge clock_i)
    if (irq) n_irq++;
  always @(posedge pclk)
    n_pclk++;
  spb_master uut (
    .clock_i(clock_i), .resetn_i(resetn_i), .flash_read_width_select_i(fw),
    .interface_protocol_select_i(3'h0), .data_width_field_i(dw),
    .port_clock_divider_reg_i(div), .setup_cnt_i(su), .pulse_cnt_i(pw),
    .hold_cnt_i(hd), .self_timed_i(st), .cfg_load_i(load), .req_valid_i(valid),
    .req_ready_o(ready), .req_write_i(wr), .req_addr_i(addr), .req_wdata_i(wdata),
    .rsp_valid_o(rvalid), .rsp_rdata_o(rdata), .rsp_timeout_o(rto), .timeout_irq_o(irq),
    .flash_read_width_o(fw_o), .interface_protocol_o(proto_o), .data_width_o(dw_o),
    .timeout_addr_o(to_addr), .port_clock_o(pclk), .addr_latch_enable_n_o(ale_n),
    .shared_addr_data_bus_i(bus), .shared_addr_data_bus_o(dout),
    .shared_addr_data_bus_oe_o(oe), .low_addr_o(), .chip_select_n_o(cs_n),
    .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n), .device_acknowledge_n_i(ack_n),
    .pack_shift_clock_o(), .pack_output_enable_n_o(), .pack_direction_o());
  spb_flash_model flash (.clock_i(clock_i), .ale_n_i(ale_n), .cs_n_i(cs_n), .wr_n_i(wr_n),
    .rd_n_i(rd_n), .bus_i(bus), .ack_dly_i(ack_dly), .bus_o(mbus), .ack_n_o(ack_n),
    .addr_o(maddr), .wbyte_o(wbyte));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cfg(input logic f, input logic [1:0] w);
    fw = f;
    dw = w;
    load = 1;
    @(posedge clock_i);
    #1 load = 0;
  endtask
  // address stays put until the answer so the checker can still see it
  task automatic xfer(input logic w, input logic [25:0] a, input logic [7:0] d);
    wr = w;
    addr = a;
    wdata = d;
    valid = 1;
    do @(negedge clock_i); while (!ready);
    @(posedge clock_i);
    #1 valid = 0;
    do @(negedge clock_i); while (!rvalid);
    got = rdata;
    @(posedge clock_i);
    #1;
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    #1 resetn_i = 1;
    check(fw_o, FRM_WIDTH_32);
    check(proto_o, PROTO_GENERIC);
    for (int i = 0; i < 3; i++) begin
      cfg(FRM_WIDTH_32, i[1:0]);
      check(dw_o, i);
    end
    cfg(FRM_WIDTH_32, DW_8BIT);
    xfer(1, 26'h0012345, 8'h3c);
    check(wbyte, 8'h3c);
    check(maddr, 24'h012345);
    xfer(0, 26'h00000fe, 8'h00);
    for (int i = 0; i < 4; i++) exp[8*i +: 8] = (8'hfe + i[7:0]) ^ 8'ha5;
    check(got, exp);
    cfg(FRM_WIDTH_8, DW_8BIT);
    xfer(0, 26'h0000033, 8'h00);
    check(got, {24'h0, 8'h33 ^ 8'ha5});
    div = 8'h02;
    cfg(FRM_WIDTH_8, DW_16BIT);
    n0 = n_pclk;
    repeat (20) @(posedge clock_i);
    #1 check(n_pclk - n0, 10);
    div = 8'h01;
    cfg(FRM_WIDTH_8, DW_16BIT);
    st = 1;
    ack_dly = 8'h03;
    xfer(1, 26'h0000077, 8'hc3);
    check(wbyte, 8'hc3);
    check(rto, 0);
    check(n_irq, 0);
    xfer(0, 26'h0000045, 8'h00);
    check({got, rto}, {24'h0, 8'h45 ^ 8'ha5, 1'b0});
    ack_dly = 8'h00;
    t0 = $time;
    xfer(1, 26'h00abcde, 8'h11);
    check(rto, 1);
    check(to_addr, 26'h00abcde);
    check(n_irq, 1);
    check((($time - t0) / 10) inside {[255:300]}, 1);
    xfer(0, 26'h2000010, 8'h00);
    check(rto, 1);
    check(to_addr, 26'h2000010);
    check(n_irq, 2);
    give_verdict();
  end
  initial begin
    #50000;
    n_mismatch++;
    give_verdict();
  end
endmodule
